// File: rtl/ufs_pkg.sv
// Purpose: shared constants and types of the flash self-program entry block
// Assumes: pclk is the instruction-cycle clock
// Notes: register offsets are word indices; byte address is four times the index
package ufs_pkg;
  localparam int ADDR_W = 12;
  localparam logic [9:0] IDX_ADDR_LO = 10'h0A8;
  localparam logic [9:0] IDX_ADDR_HI = 10'h0A9;
  localparam logic [9:0] IDX_RD_DATA = 10'h0AA;
  localparam logic [9:0] IDX_WR_DATA = 10'h0AB;
  localparam logic [9:0] IDX_PGM_TIM = 10'h0E1;
  localparam logic [9:0] IDX_UNLOCK = 10'h0E2;
  localparam logic [9:0] IDX_BYTE_CNT = 10'h0F1;
  localparam logic [9:0] IDX_JUMP = 10'h0C0;
  localparam logic [9:0] IDX_STATUS = 10'h0C1;
  // jump register fields
  localparam int JMP_EP_LSB = 0;
  localparam int JMP_ACC_LSB = 8;
  localparam int JMP_X_LSB = 16;
  // status register bits
  localparam int ST_BUSY = 0;
  localparam int ST_ISP = 1;
  localparam int ST_REJECT = 2;
  localparam int ST_REFUSED = 3;
  // entry points
  localparam logic [7:0] EP_ISP = 8'h00;
  localparam logic [7:0] EP_READ = 8'h11;
  localparam logic [7:0] EP_WRITE = 8'h14;
  localparam logic [7:0] EP_PAGE = 8'h17;
  localparam logic [7:0] EP_MASS = 8'h1A;
  localparam logic [7:0] EP_BLK_WR = 8'h23;
  localparam logic [7:0] EP_BLK_RD = 8'h26;
  localparam logic [7:0] EP_EXIT = 8'h62;
  localparam logic [7:0] MASS_CONFIRM = 8'h55;
  localparam logic [7:0] UNLOCK_KEY = 8'h98;
  localparam logic [7:0] BLK_WR_MAX = 8'h10;
  localparam logic [2:0] KEY_WINDOW = 3'h6;
  localparam logic [7:0] ERASED = 8'hFF;
  localparam logic [7:0] REG_RST = 8'h00;
  typedef enum logic [3:0] {
    S_IDLE, S_READ, S_PROG, S_BWR_REQ, S_BWR_WAIT, S_BWR_DATA, S_BRD, S_ERASE, S_ISP
  } ufs_state_t;
endpackage

// File: rtl/ufs_key_if.sv
// Purpose: unlock handshake between the register core and the key gate
// Assumes: one clock domain
// Notes: jump_ok is combinational from the gate state
`timescale 1ns/1ns
interface ufs_key_if;
  logic key_wr;
  logic [7:0] key_val;
  logic jump_req;
  logic jump_ok;
  modport core (output key_wr, output key_val, output jump_req, input jump_ok);
  modport gate (input key_wr, input key_val, input jump_req, output jump_ok);
endinterface

// File: rtl/ufs_key_gate.sv
// Purpose: tracks the unlock key and its short validity window
// Assumes: one pclk cycle per instruction cycle
// Notes: a key write arms the gate for a single jump only
`timescale 1ns/1ns
module ufs_key_gate (
  input wire logic pclk,
  input wire logic presetn,
  ufs_key_if.gate kif
);
  import ufs_pkg::*;
  logic armed;
  logic [2:0] age;
  wire logic lapse = armed && (age == KEY_WINDOW);

  assign kif.jump_ok = armed && (age <= KEY_WINDOW);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed <= 1'b0;
      age <= 3'h0;
    end else if (kif.key_wr) begin
      armed <= (kif.key_val == UNLOCK_KEY);
      age <= 3'h1;
    end else if (kif.jump_req || lapse) begin
      armed <= 1'b0;
    end else if (armed) begin
      age <= age + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  key_lapse_a: assert property (@(posedge pclk) disable iff (!presetn)
    kif.key_wr ##1 (!kif.key_wr)[*7] |-> !kif.jump_ok)
    else $error("unlock still open after window");
  key_good_a: assert property (@(posedge pclk) disable iff (!presetn)
    (kif.key_wr && kif.key_val == UNLOCK_KEY) ##1 (!kif.key_wr && !kif.jump_req)[*5] ##1 !kif.key_wr
    |-> kif.jump_ok)
    else $error("valid key refused inside window");
  key_value_a: assert property (@(posedge pclk) disable iff (!presetn)
    (kif.key_wr && kif.key_val != UNLOCK_KEY) ##1 !kif.key_wr |-> !kif.jump_ok)
    else $error("wrong key opened the gate");
  single_jump_a: assert property (@(posedge pclk) disable iff (!presetn)
    (kif.jump_req && !kif.key_wr) ##1 !kif.key_wr |-> !kif.jump_ok)
    else $error("key reused for second jump");
endmodule // ufs_key_gate

// File: rtl/ufs_flash_entry.sv
// Purpose: APB-reached self-programming entry into the on-chip program flash
// Assumes: RAM returns ram_rdata one cycle after ram_rd; isp_exit is a pin
// Notes: pclk is the instruction-cycle clock; flash array lives here
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ns
// Notes on behaviour
// - entry 0x17 erases the page holding the address-high/low location
// - entry 0x1A mass erases only with 0x55 in the accumulator
// - entry 0x11 reads the addressed flash byte into the read-data register
// - entry 0x26 copies n flash bytes to RAM at X, n up to 255
// - entry 0x23 programs n RAM bytes from X into flash, n up to 16
// - entry 0x14 programs the write-data byte at the address
// - entry 0x62 resets the whole device
// - entry 0x00 enters serial programming mode until the isp_exit pin resets
// - jump accepted only within 6 cycles after the key write
// - only key value 0x98 unlocks the jump
// - flash address is high byte at 0xA9 and low byte at 0xA8
module ufs_flash_entry #(
  parameter int FLASH_AW = 13,
  parameter int PAGE_BYTES = 128
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [ufs_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [7:0] ram_addr,
  output logic [7:0] ram_wdata,
  output logic ram_we,
  output logic ram_rd,
  input wire logic [7:0] ram_rdata,
  input wire logic isp_exit,
  output logic isp_mode,
  output logic device_reset
);
  import ufs_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // registers and state
  logic [7:0] flash_address_low;
  logic [7:0] flash_address_high;
  logic [7:0] flash_read_data;
  logic [7:0] flash_write_data;
  logic [7:0] program_timing;
  logic [7:0] block_byte_count;
  logic st_reject;
  logic st_refused;
  ufs_state_t state;
  logic [15:0] flash_addr;
  logic [15:0] erase_left;
  logic [7:0] cnt;
  logic [7:0] timer;
  logic [7:0] ram_ptr;
  logic [7:0] wr_byte;
  logic mass_run;
  logic exit_s1;
  logic exit_s2;
  logic [7:0] flash_mem [2**FLASH_AW];
  ufs_key_if kif ();

  ufs_key_gate u_gate (
    .pclk(pclk),
    .presetn(presetn),
    .kif(kif)
  );

  function automatic logic hit(input logic [9:0] idx);
    return idx == IDX_ADDR_LO || idx == IDX_ADDR_HI || idx == IDX_RD_DATA || idx == IDX_WR_DATA ||
      idx == IDX_PGM_TIM || idx == IDX_UNLOCK || idx == IDX_BYTE_CNT || idx == IDX_JUMP ||
      idx == IDX_STATUS;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // bus decode
  wire logic [9:0] idx = paddr[ADDR_W-1:2];
  wire logic access = psel && penable;
  wire logic mapped = hit(idx) && (paddr[1:0] == 2'h0);
  wire logic wr_en = access && pready && pwrite && mapped;
  wire logic jump_wr = wr_en && (idx == IDX_JUMP);
  wire logic [7:0] j_ep = pwdata[JMP_EP_LSB +: 8];
  wire logic [7:0] j_acc = pwdata[JMP_ACC_LSB +: 8];
  wire logic [7:0] j_x = pwdata[JMP_X_LSB +: 8];
  wire logic busy = (state != S_IDLE);
  wire logic known_ep = j_ep == EP_ISP || j_ep == EP_READ || j_ep == EP_WRITE || j_ep == EP_PAGE ||
    j_ep == EP_MASS || j_ep == EP_BLK_WR || j_ep == EP_BLK_RD || j_ep == EP_EXIT;
  wire logic go = jump_wr && kif.jump_ok && !busy && known_ep;
  wire logic mass_bad = go && (j_ep == EP_MASS) && (j_acc != MASS_CONFIRM);
  wire logic bwr_bad = go && (j_ep == EP_BLK_WR) && (block_byte_count > BLK_WR_MAX);
  wire logic st_clr = wr_en && (idx == IDX_STATUS);
  wire logic [15:0] req_addr = {flash_address_high, flash_address_low};
  wire logic [15:0] page_base = req_addr & ~16'(PAGE_BYTES - 1);
  wire logic [31:0] status_word = {28'h0, st_refused, st_reject, isp_mode, busy};
  logic [31:0] rd_mux;
  always_comb begin
    case (idx)
      IDX_ADDR_LO: rd_mux = {24'h0, flash_address_low};
      IDX_ADDR_HI: rd_mux = {24'h0, flash_address_high};
      IDX_RD_DATA: rd_mux = {24'h0, flash_read_data};
      IDX_WR_DATA: rd_mux = {24'h0, flash_write_data};
      IDX_PGM_TIM: rd_mux = {24'h0, program_timing};
      IDX_BYTE_CNT: rd_mux = {24'h0, block_byte_count};
      IDX_STATUS: rd_mux = status_word;
      default: rd_mux = 32'h0;
    endcase
  end

  assign kif.key_wr = wr_en && (idx == IDX_UNLOCK);
  assign kif.key_val = pwdata[7:0];
  assign kif.jump_req = jump_wr;

  ////////////////////////////////////////////////////////////////////////
  // flash array port
  wire logic prog_fire = (state == S_PROG) && (timer == 8'h0);
  wire logic erase_fire = (state == S_ERASE) && (timer == 8'h0);
  wire logic [FLASH_AW-1:0] mem_wa = flash_addr[FLASH_AW-1:0];
  wire logic [7:0] cur_byte = flash_mem[mem_wa];
  wire logic [7:0] mem_wd = erase_fire ? ERASED : wr_byte;

  always_ff @(posedge pclk) begin
    if (prog_fire || erase_fire) begin
      flash_mem[mem_wa] <= mem_wd;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // apb answer: one wait state per access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else if (access && !pready) begin
      pready <= 1'b1;
      pslverr <= !mapped;
      prdata <= (mapped && !pwrite) ? rd_mux : 32'h0;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // software registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_address_low <= REG_RST;
      flash_address_high <= REG_RST;
      flash_read_data <= REG_RST;
      flash_write_data <= REG_RST;
      program_timing <= REG_RST;
      block_byte_count <= REG_RST;
      st_reject <= 1'b0;
      st_refused <= 1'b0;
    end else begin
      if (wr_en && idx == IDX_ADDR_LO) flash_address_low <= pwdata[7:0];
      if (wr_en && idx == IDX_ADDR_HI) flash_address_high <= pwdata[7:0];
      if (state == S_READ) flash_read_data <= cur_byte;
      else if (wr_en && idx == IDX_RD_DATA) flash_read_data <= pwdata[7:0];
      if (wr_en && idx == IDX_WR_DATA) flash_write_data <= pwdata[7:0];
      if (wr_en && idx == IDX_PGM_TIM) program_timing <= pwdata[7:0];
      if (wr_en && idx == IDX_BYTE_CNT) block_byte_count <= pwdata[7:0];
      // set wins over a same-cycle clear
      st_reject <= (jump_wr && !go) || (st_reject && !(st_clr && pwdata[ST_REJECT]));
      st_refused <= mass_bad || bwr_bad || (st_refused && !(st_clr && pwdata[ST_REFUSED]));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // exit pin synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exit_s1 <= 1'b0;
      exit_s2 <= 1'b0;
    end else begin
      exit_s1 <= isp_exit;
      exit_s2 <= exit_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // routine sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= S_IDLE;
      flash_addr <= 16'h0;
      erase_left <= 16'h0;
      cnt <= 8'h0;
      timer <= 8'h0;
      ram_ptr <= 8'h0;
      wr_byte <= 8'h0;
      mass_run <= 1'b0;
      ram_addr <= 8'h0;
      ram_wdata <= 8'h0;
      ram_we <= 1'b0;
      ram_rd <= 1'b0;
      isp_mode <= 1'b0;
      device_reset <= 1'b0;
    end else begin
      ram_we <= 1'b0;
      ram_rd <= 1'b0;
      device_reset <= 1'b0;
      case (state)
        S_IDLE: begin
          if (go && !mass_bad && !bwr_bad) begin
            flash_addr <= req_addr;
            cnt <= block_byte_count;
            ram_ptr <= j_x;
            timer <= program_timing;
            mass_run <= 1'b0;
            case (j_ep)
              EP_READ: state <= S_READ;
              EP_WRITE: begin
                wr_byte <= flash_write_data;
                cnt <= 8'h0;
                state <= S_PROG;
              end
              EP_PAGE: begin
                flash_addr <= page_base;
                erase_left <= 16'(PAGE_BYTES - 1);
                state <= S_ERASE;
              end
              EP_MASS: begin
                flash_addr <= 16'h0;
                erase_left <= 16'(2**FLASH_AW - 1);
                mass_run <= 1'b1;
                state <= S_ERASE;
              end
              EP_BLK_WR: state <= (block_byte_count == 8'h0) ? S_IDLE : S_BWR_REQ;
              EP_BLK_RD: state <= S_BRD;
              EP_EXIT: device_reset <= 1'b1;
              EP_ISP: begin
                isp_mode <= 1'b1;
                state <= S_ISP;
              end
              default: state <= S_IDLE;
            endcase
          end
        end
        S_READ: state <= S_IDLE;
        S_BWR_REQ: begin
          ram_addr <= ram_ptr;
          ram_rd <= 1'b1;
          state <= S_BWR_WAIT;
        end
        S_BWR_WAIT: state <= S_BWR_DATA;
        S_BWR_DATA: begin
          wr_byte <= ram_rdata;
          timer <= program_timing;
          cnt <= cnt - 8'h1;
          state <= S_PROG;
        end
        S_PROG: begin
          if (timer != 8'h0) begin
            timer <= timer - 8'h1;
          end else if (cnt != 8'h0) begin
            flash_addr <= flash_addr + 16'h1;
            ram_ptr <= ram_ptr + 8'h1;
            state <= S_BWR_REQ;
          end else begin
            state <= S_IDLE;
          end
        end
        S_BRD: begin
          if (cnt != 8'h0) begin
            ram_addr <= ram_ptr;
            ram_wdata <= cur_byte;
            ram_we <= 1'b1;
            ram_ptr <= ram_ptr + 8'h1;
            flash_addr <= flash_addr + 16'h1;
            cnt <= cnt - 8'h1;
          end else begin
            state <= S_IDLE;
          end
        end
        S_ERASE: begin
          if (timer != 8'h0) begin
            timer <= timer - 8'h1;
          end else if (erase_left != 16'h0) begin
            flash_addr <= flash_addr + 16'h1;
            erase_left <= erase_left - 16'h1;
          end else if (mass_run) begin
            isp_mode <= 1'b1; // mass erase falls into serial mode
            state <= S_ISP;
          end else begin
            state <= S_IDLE;
          end
        end
        S_ISP: begin
          if (exit_s2) begin
            isp_mode <= 1'b0;
            device_reset <= 1'b1;
            state <= S_IDLE;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  page_erase_a: assert property (@(posedge pclk) disable iff (!presetn)
    (go && j_ep == EP_PAGE) |=> (state == S_ERASE) && (flash_addr == $past(page_base))
    && (erase_left == 16'(PAGE_BYTES - 1)))
    else $error("page erase started wrongly");
  mass_confirm_a: assert property (@(posedge pclk) disable iff (!presetn)
    (go && j_ep == EP_MASS) |=> (state == S_ERASE) == ($past(j_acc) == MASS_CONFIRM))
    else $error("mass erase confirmation ignored");
  read_byte_a: assert property (@(posedge pclk) disable iff (!presetn)
    (go && j_ep == EP_READ) |=> (state == S_READ) ##1 (flash_read_data == $past(cur_byte)))
    else $error("read byte not returned");
  blk_copy_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state == S_BRD && cnt != 8'h0) |=> ram_we && (ram_addr == $past(ram_ptr))
    && (ram_wdata == $past(cur_byte)))
    else $error("block read copy wrong");
  blk_fetch_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state == S_BWR_REQ) |=> ram_rd ##1 !ram_rd ##1 (state == S_PROG))
    else $error("block write fetch order wrong");
  write_byte_a: assert property (@(posedge pclk) disable iff (!presetn)
    (go && j_ep == EP_WRITE) |=> (state == S_PROG) && (wr_byte == $past(flash_write_data)))
    else $error("write byte not latched");
  exit_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
    (go && j_ep == EP_EXIT) |=> device_reset ##1 !device_reset)
    else $error("exit did not reset");
  isp_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state == S_ISP && !exit_s2) |=> isp_mode && !device_reset)
    else $error("serial mode left early");
  unlock_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    (jump_wr && !kif.jump_ok && !busy) |=> (state == S_IDLE) && st_reject)
    else $error("unvalidated jump entered");
  addr_load_a: assert property (@(posedge pclk) disable iff (!presetn)
    (go && j_ep == EP_READ) |=> (flash_addr == $past(req_addr)))
    else $error("flash address not taken from registers");
  blk_refuse_a: assert property (@(posedge pclk) disable iff (!presetn)
    (go && j_ep == EP_BLK_WR && block_byte_count > BLK_WR_MAX) |=> (state == S_IDLE) && st_refused)
    else $error("oversized block write started");
  blk_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state == S_BRD && cnt == 8'h0) |=> !ram_we && (state == S_IDLE))
    else $error("block read overran its count");
  isp_entry_a: assert property (@(posedge pclk) disable iff (!presetn)
    (go && j_ep == EP_ISP) |=> isp_mode && (state == S_ISP))
    else $error("serial mode not entered");
endmodule // ufs_flash_entry

// File: tb/ufs_ram_model.sv
// Purpose: synchronous data RAM on the far side of the block-copy port
// Assumes: read data appears one cycle after the read strobe
// Notes: outside that cycle the data lines toggle every cycle
`timescale 1ns/1ns
module ufs_ram_model (
  input wire logic pclk,
  input wire logic [7:0] ram_addr,
  input wire logic [7:0] ram_wdata,
  input wire logic ram_we,
  input wire logic ram_rd,
  output logic [7:0] ram_rdata
);
  logic [7:0] mem [256];
  initial ram_rdata = 8'hA5;
  always @(posedge pclk) begin
    if (ram_we) begin
      mem[ram_addr] <= ram_wdata;
    end
    if (ram_rd) begin
      ram_rdata <= mem[ram_addr];
    end else begin
      ram_rdata <= ~ram_rdata;
    end
  end
endmodule // ufs_ram_model

// File: tb/tb_top.sv
// Purpose: self-checking bench of the flash self-program entry block
// Assumes: APB master with one idle cycle between transfers
// Notes: flash model fm is filled only where the bench knows the contents
`timescale 1ns/1ns
module tb_top;
  import ufs_pkg::*;
  localparam int FAW = 10;
  localparam logic [7:0] T = 8'h03;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, isp_exit = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd, w;
  logic pready, pslverr, err, isp_mode, device_reset, ram_we, ram_rd;
  logic [7:0] ram_addr, ram_wdata, ram_rdata, v;
  logic [7:0] fm [1024];
  int failures = 0, tests_run = 0, resets = 0, n0;
  logic [9:0] regs [6] = '{IDX_ADDR_LO, IDX_ADDR_HI, IDX_RD_DATA, IDX_WR_DATA, IDX_PGM_TIM, IDX_BYTE_CNT};
  logic [7:0] keys [4] = '{8'h98, 8'h98, 8'h97, 8'h98};
  logic [7:0] eps [4] = '{8'h11, 8'h11, 8'h11, 8'h33};
  int gaps [4] = '{2, 3, 0, 0};
  logic rej [4] = '{1'b0, 1'b1, 1'b1, 1'b1};
  always #20 pclk = ~pclk;
  always @(posedge pclk) if (device_reset === 1'b1) resets++;
  ufs_flash_entry #(.FLASH_AW(FAW)) dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ram_addr(ram_addr), .ram_wdata(ram_wdata), .ram_we(ram_we), .ram_rd(ram_rd), .ram_rdata(ram_rdata),
    .isp_exit(isp_exit), .isp_mode(isp_mode), .device_reset(device_reset));
  ufs_ram_model ram_u (.pclk(pclk), .ram_addr(ram_addr), .ram_wdata(ram_wdata), .ram_we(ram_we),
    .ram_rd(ram_rd), .ram_rdata(ram_rdata));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic hang();
    failures++;
    give_verdict();
  endtask
  task automatic apb(input bit wr, input logic [9:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) hang();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    apb(1'b1, idx, {24'h0, d});
  endtask
  task automatic rchk(input string what, input logic [9:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk(what, exp, rd);
  endtask
  task automatic set_addr(input logic [15:0] a);
    wr(IDX_ADDR_HI, a[15:8]);
    wr(IDX_ADDR_LO, a[7:0]);
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      apb(1'b0, IDX_STATUS, 32'h0);
      n++;
    end while (rd[ST_BUSY] !== 1'b0 && n < 600);
    if (rd[ST_BUSY] !== 1'b0) hang();
  endtask
  task automatic wait_isp();
    int n;
    n = 0;
    while (isp_mode !== 1'b1 && n < 3000) begin
      @(posedge pclk);
      n++;
    end
    if (isp_mode !== 1'b1) hang();
  endtask
  // key, gap in idle cycles after the key write's trailing idle, then the jump word
  task automatic jump(input logic [7:0] key, input int gap, input logic [7:0] ep, input logic [7:0] acc,
    input logic [7:0] x);
    wr(IDX_UNLOCK, key);
    repeat (gap) @(posedge pclk);
    apb(1'b1, IDX_JUMP, {8'h00, x, acc, ep});
    if (ep == EP_ISP || (ep == EP_MASS && acc == MASS_CONFIRM)) wait_isp();
    else wait_idle();
  endtask
  task automatic rd_byte(input logic [15:0] a);
    set_addr(a);
    jump(UNLOCK_KEY, 0, EP_READ, 8'h00, 8'h00);
    rchk("flash byte", IDX_RD_DATA, {24'h0, fm[a[FAW-1:0]]});
  endtask
  task automatic do_reset();
    presetn <= 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #3000000;
    hang();
  end
  initial begin
    void'($urandom(82270));
    foreach (ram_u.mem[i]) ram_u.mem[i] = 8'($urandom);
    do_reset();
    for (int i = 0; i < 6; i++) begin
      rchk("reset value", regs[i], {24'h0, REG_RST});
      w = $urandom;
      apb(1'b1, regs[i], w);
      rchk("register readback", regs[i], {24'h0, w[7:0]});
    end
    wr(IDX_UNLOCK, 8'h5A);
    rchk("unlock reads zero", IDX_UNLOCK, 32'h0);
    apb(1'b0, 10'h0A0, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
    $display("test registers done");
    wr(IDX_PGM_TIM, T);
    set_addr(16'h0105);
    jump(UNLOCK_KEY, 0, EP_PAGE, 8'h00, 8'h00);
    for (int i = 'h100; i < 'h180; i++) fm[i] = ERASED;
    v = 8'($urandom);
    wr(IDX_WR_DATA, v);
    jump(UNLOCK_KEY, 0, EP_WRITE, 8'h00, 8'h00);
    fm['h105] = v;
    rd_byte(16'h0105);
    rd_byte(16'h0100);
    rd_byte(16'h017F);
    $display("test byte write done");
    set_addr(16'h0000);
    jump(UNLOCK_KEY, 0, EP_PAGE, 8'h00, 8'h00);
    for (int i = 0; i < 'h80; i++) fm[i] = ERASED;
    set_addr(16'h0040);
    wr(IDX_BYTE_CNT, BLK_WR_MAX);
    jump(UNLOCK_KEY, 0, EP_BLK_WR, 8'h00, 8'h10);
    for (int i = 0; i < 16; i++) fm['h40 + i] = ram_u.mem['h10 + i];
    set_addr(16'h0030);
    wr(IDX_BYTE_CNT, 8'd40);
    jump(UNLOCK_KEY, 0, EP_BLK_RD, 8'h00, 8'h80);
    for (int i = 0; i < 40; i++) chk("ram copy", {24'h0, fm['h30 + i]}, {24'h0, ram_u.mem['h80 + i]});
    $display("test block copy done");
    set_addr(16'h0045);
    for (int i = 0; i < 4; i++) begin
      wr(IDX_RD_DATA, ~fm['h45]);
      jump(keys[i], gaps[i], eps[i], 8'h00, 8'h00);
      chk("jump rejected", {31'h0, rej[i]}, {31'h0, rd[ST_REJECT]});
      rchk("read after jump", IDX_RD_DATA, {24'h0, rej[i] ? ~fm['h45] : fm['h45]});
      wr(IDX_STATUS, 8'h0C);
    end
    jump(UNLOCK_KEY, 0, EP_READ, 8'h00, 8'h00);
    apb(1'b1, IDX_JUMP, {24'h0, EP_READ});
    wait_idle();
    chk("second jump rejected", 32'h1, {31'h0, rd[ST_REJECT]});
    wr(IDX_STATUS, 8'h0C);
    jump(UNLOCK_KEY, 0, EP_MASS, 8'h54, 8'h00);
    chk("mass erase refused", 32'h1, {31'h0, rd[ST_REFUSED]});
    rd_byte(16'h0045);
    wr(IDX_STATUS, 8'h0C);
    wr(IDX_BYTE_CNT, 8'h11);
    jump(UNLOCK_KEY, 0, EP_BLK_WR, 8'h00, 8'h00);
    chk("block write refused", 32'h1, {31'h0, rd[ST_REFUSED]});
    $display("test unlock and refusals done");
    n0 = resets;
    jump(UNLOCK_KEY, 0, EP_EXIT, 8'h00, 8'h00);
    chk("reset pulses", n0 + 1, resets);
    do_reset();
    jump(UNLOCK_KEY, 0, EP_ISP, 8'h00, 8'h00);
    chk("serial mode", 32'h1, {31'h0, isp_mode});
    n0 = resets;
    isp_exit <= 1'b1;
    repeat (8) @(posedge pclk);
    chk("serial mode left", 32'h0, {31'h0, isp_mode});
    chk("reset pulses", n0 + 1, resets);
    isp_exit <= 1'b0;
    do_reset();
    $display("test exit paths done");
    wr(IDX_PGM_TIM, T);
    jump(UNLOCK_KEY, 0, EP_MASS, MASS_CONFIRM, 8'h00);
    foreach (fm[i]) fm[i] = ERASED;
    do_reset();
    rd_byte(16'h0045);
    rd_byte(16'h03FF);
    $display("test mass erase done");
    give_verdict();
  end
endmodule // tb_top
